/* pkg/clock_gate_pkg.sv */
// Purpose: shared constants for the clock gate enable/status block
// Assumes: 32-bit apb data, byte addresses, one register per word
// Notes: offsets are byte addresses within the block window
package clock_gate_pkg;

	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFF_SYSTEM_CLOCK_ENABLE = 8'h00;
	localparam logic [7:0] OFF_SYSTEM_CLOCK_DISABLE = 8'h04;
	localparam logic [7:0] OFF_SYSTEM_CLOCK_STATUS = 8'h08;
	localparam logic [7:0] OFF_PERIPHERAL_CLOCK_ENABLE = 8'h10;
	localparam logic [7:0] OFF_PERIPHERAL_CLOCK_DISABLE = 8'h14;
	localparam logic [7:0] OFF_PERIPHERAL_CLOCK_STATUS = 8'h18;

	// system clock field positions
	localparam int BIT_PROCESSOR = 0;
	localparam int BIT_HOST_PORT = 6;
	localparam int BIT_DEVICE_PORT = 7;
	localparam int BIT_PROG_ZERO = 8;
	localparam int BIT_PROG_ONE = 9;

	// bits that each system register acts on
	localparam logic [31:0] SYSTEM_ENABLE_MASK = 32'h0000_03c0;
	localparam logic [31:0] SYSTEM_DISABLE_MASK = 32'h0000_03c1;

	// peripheral identifiers 2..31 exist as gate bits
	localparam logic [31:0] PERIPHERAL_ID_MASK = 32'hffff_fffc;
	localparam int PERIPHERAL_FIRST = 2;
	localparam int PERIPHERAL_LAST = 31;

	// reset values
	localparam logic [31:0] SYSTEM_STATUS_RESET = 32'h0000_0003;
	localparam logic [31:0] PERIPHERAL_STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : clock_gate_pkg

/* verilog/clock_gate_cell.sv */
// Purpose: glitch-free gate for one copy of the master clock
// Assumes: enable changes only just after a rising edge of clk
// Notes: enable is retimed on the falling edge so the and gate only
//        switches while clk is low; no runt pulse can escape
`timescale 1ns/1ps
module clock_gate_cell #(
	parameter logic reset_open = 1'b0
) (
	input wire logic clk,
	input wire logic presetn,
	input wire logic enable,
	output logic gated_clk
);

	logic enable_low;

	// retime enable while clk is low
	always_ff @(negedge clk or negedge presetn) begin
		if (!presetn) begin
			enable_low <= reset_open;
		end else begin
			enable_low <= enable;
		end
	end

	// gated copy of the master clock
	assign gated_clk = clk & enable_low;

endmodule : clock_gate_cell

/* verilog/clock_gate_enable_status.sv */
// Purpose: clock gating with set/clear/status registers on apb
// Assumes: pclk is the master clock; apb master follows the protocol
// Notes: prdata and pslverr are captured in the setup cycle, pready
//        is high in every access phase, so each transfer is two cycles
//        an access phase counts only right after its setup cycle
//        gates switch while pclk is low, so no clock pulse is cut short
//
// Functional notes
// - system disable bit 0 stops processor clock
// - system disable bit 6 gates host port clocks
// - system disable bit 7 gates device port clock
// - system disable bits 8/9 stop programmable outputs
// - system enable bits 8/9 start programmable outputs
// - status bit 0 shows processor clock running
// - status bit 6 shows host port clock state
// - status bit 7 shows device port clock state
// - status bits 8/9 show programmable output state
// - peripheral enable bits 2..31 open gates
// - peripheral disable bits 2..31 close gates
// - peripheral status bits 2..31 show gate state
// - unimplemented peripheral identifiers change nothing
// - system enable bit 6 opens host port clocks
// - system enable bit 7 opens device port clock
// - peripheral clocks are gated master clock copies
`timescale 1ns/1ps
module clock_gate_enable_status
	import clock_gate_pkg::*;
#(
	parameter logic [31:0] implemented_peripherals = PERIPHERAL_ID_MASK
) (
	// master clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb requests
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	// apb response
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// processor wake request
	input wire logic processor_wake,
	// gated clocks and idle flag
	output logic processor_clock,
	output logic processor_idle,
	output logic host_port_clock,
	output logic device_port_clock,
	output logic programmable_output_zero,
	output logic programmable_output_one,
	output logic [31:0] peripheral_clock
);

	// set bits open, clear bits close, both limited to allowed gates
	function automatic logic [31:0] apply_set_clear(
		input logic [31:0] current,
		input logic [31:0] set_bits,
		input logic [31:0] clear_bits,
		input logic [31:0] allowed
	);
		logic [31:0] opened;
		logic [31:0] closed;
		opened = current | (set_bits & allowed);
		closed = clear_bits & allowed;
		apply_set_clear = opened & ~closed;
	endfunction : apply_set_clear

	// address match on the exact byte offset of a register
	function automatic logic hit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0] offset
	);
		hit = (addr == offset);
	endfunction : hit

	// write-one strobe of one register, zero unless that register is written
	function automatic logic [31:0] write_strobe(
		input logic commit,
		input logic selected,
		input logic [31:0] data
	);
		write_strobe = (commit & selected) ? data : READ_ZERO;
	endfunction : write_strobe

	// phase of the bus in the cycle just finished
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_SETUP = 2'b01,
		BUS_ACCESS = 2'b10
	} bus_phase_t;

	// gate enable flops, read back as status
	logic [31:0] system_gate;
	logic [31:0] peripheral_gate;
	logic [31:0] next_system_gate;
	logic [31:0] next_peripheral_gate;

	// bus phase tracking
	bus_phase_t bus_phase;
	bus_phase_t next_bus_phase;

	// apb phase decode
	wire setup_phase;
	wire access_phase;
	wire access_valid;
	wire write_commit;
	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;

	// validate the current cycle against the one before it
	always_comb begin
		next_bus_phase = BUS_IDLE;
		case (bus_phase)
			BUS_IDLE: begin
				if (setup_phase) begin
					next_bus_phase = BUS_SETUP;
				end
			end
			BUS_SETUP: begin
				if (access_phase) begin
					next_bus_phase = BUS_ACCESS;
				end else if (setup_phase) begin
					next_bus_phase = BUS_SETUP;
				end
			end
			BUS_ACCESS: begin
				if (setup_phase) begin
					next_bus_phase = BUS_SETUP;
				end
			end
			default: begin
				next_bus_phase = BUS_IDLE;
			end
		endcase
	end

	// phase register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_phase <= BUS_IDLE;
		end else begin
			bus_phase <= next_bus_phase;
		end
	end

	// an access phase without its setup cycle writes nothing
	assign access_valid = access_phase & (bus_phase == BUS_SETUP);
	assign write_commit = access_valid & pwrite;

	// register decode
	wire hit_system_enable;
	wire hit_system_disable;
	wire hit_system_status;
	wire hit_peripheral_enable;
	wire hit_peripheral_disable;
	wire hit_peripheral_status;
	wire mapped;
	assign hit_system_enable = hit(paddr, OFF_SYSTEM_CLOCK_ENABLE);
	assign hit_system_disable = hit(paddr, OFF_SYSTEM_CLOCK_DISABLE);
	assign hit_system_status = hit(paddr, OFF_SYSTEM_CLOCK_STATUS);
	assign hit_peripheral_enable = hit(paddr, OFF_PERIPHERAL_CLOCK_ENABLE);
	assign hit_peripheral_disable = hit(paddr, OFF_PERIPHERAL_CLOCK_DISABLE);
	assign hit_peripheral_status = hit(paddr, OFF_PERIPHERAL_CLOCK_STATUS);
	assign mapped = hit_system_enable
		| hit_system_disable
		| hit_system_status
		| hit_peripheral_enable
		| hit_peripheral_disable
		| hit_peripheral_status;

	// write-one strobes per register; zero bits carry no action
	wire [31:0] system_set;
	wire [31:0] system_clear;
	wire [31:0] peripheral_set;
	wire [31:0] peripheral_clear;
	wire [31:0] wake_set;
	assign system_set = write_strobe(write_commit, hit_system_enable, pwdata);
	assign system_clear = write_strobe(write_commit, hit_system_disable, pwdata);
	assign peripheral_set = write_strobe(write_commit, hit_peripheral_enable, pwdata);
	assign peripheral_clear = write_strobe(write_commit, hit_peripheral_disable, pwdata);

	// a wake request reopens the processor clock and wins over a disable
	assign wake_set = processor_wake ? (32'h0000_0001 << BIT_PROCESSOR) : READ_ZERO;

	// bits each system register may move; enable cannot touch processor bit
	wire [31:0] system_open_bits;
	wire [31:0] system_close_bits;
	assign system_open_bits = system_set & SYSTEM_ENABLE_MASK;
	assign system_close_bits = system_clear & SYSTEM_DISABLE_MASK;

	// next system gate state
	wire [31:0] system_after_write;
	assign system_after_write = apply_set_clear(system_gate, system_open_bits,
		system_close_bits, SYSTEM_DISABLE_MASK);
	assign next_system_gate = system_after_write | wake_set;

	// identifiers that own a gate; all others ignore writes
	wire [31:0] peripheral_allowed;
	assign peripheral_allowed = implemented_peripherals & PERIPHERAL_ID_MASK;

	// next peripheral gate state, only implemented identifiers move
	assign next_peripheral_gate = apply_set_clear(peripheral_gate, peripheral_set,
		peripheral_clear, peripheral_allowed);

	// system gate enable flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_gate <= SYSTEM_STATUS_RESET;
		end else begin
			system_gate <= next_system_gate;
		end
	end

	// peripheral gate enable flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peripheral_gate <= PERIPHERAL_STATUS_RESET;
		end else begin
			peripheral_gate <= next_peripheral_gate;
		end
	end

	// status words; bits without a gate keep their reset level
	wire [31:0] system_status_word;
	wire [31:0] peripheral_status_word;
	assign system_status_word = (system_gate & SYSTEM_DISABLE_MASK)
		| (SYSTEM_STATUS_RESET & ~SYSTEM_DISABLE_MASK);
	assign peripheral_status_word = peripheral_gate & peripheral_allowed;

	// read data selection; write-only registers read as zero
	wire [31:0] read_value;
	assign read_value = hit_system_status ? system_status_word
		: hit_peripheral_status ? peripheral_status_word
		: READ_ZERO;

	// response values, loaded only at the setup edge
	wire [31:0] next_prdata;
	wire next_pslverr;
	assign next_prdata = pwrite ? READ_ZERO : read_value;
	assign next_pslverr = ~mapped;

	// read data and error captured in the setup cycle, held in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= READ_ZERO;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// zero wait states
	assign pready = 1'b1;

	// per-gate enables picked out of the system flops
	wire processor_open;
	wire host_port_open;
	wire device_port_open;
	wire prog_zero_open;
	wire prog_one_open;
	assign processor_open = system_gate[BIT_PROCESSOR];
	assign host_port_open = system_gate[BIT_HOST_PORT];
	assign device_port_open = system_gate[BIT_DEVICE_PORT];
	assign prog_zero_open = system_gate[BIT_PROG_ZERO];
	assign prog_one_open = system_gate[BIT_PROG_ONE];

	// idle indication for the processor
	assign processor_idle = ~processor_open;

	// system clock gates, each following its enable flop
	clock_gate_cell #(
		.reset_open(SYSTEM_STATUS_RESET[BIT_PROCESSOR])
	) processor_gate (
		.clk(pclk),
		.presetn(presetn),
		.enable(processor_open),
		.gated_clk(processor_clock)
	);

	clock_gate_cell #(
		.reset_open(SYSTEM_STATUS_RESET[BIT_HOST_PORT])
	) host_port_clock_gate (
		.clk(pclk),
		.presetn(presetn),
		.enable(host_port_open),
		.gated_clk(host_port_clock)
	);

	clock_gate_cell #(
		.reset_open(SYSTEM_STATUS_RESET[BIT_DEVICE_PORT])
	) device_port_clock_gate (
		.clk(pclk),
		.presetn(presetn),
		.enable(device_port_open),
		.gated_clk(device_port_clock)
	);

	clock_gate_cell #(
		.reset_open(SYSTEM_STATUS_RESET[BIT_PROG_ZERO])
	) programmable_output_gate_zero (
		.clk(pclk),
		.presetn(presetn),
		.enable(prog_zero_open),
		.gated_clk(programmable_output_zero)
	);

	clock_gate_cell #(
		.reset_open(SYSTEM_STATUS_RESET[BIT_PROG_ONE])
	) programmable_output_gate_one (
		.clk(pclk),
		.presetn(presetn),
		.enable(prog_one_open),
		.gated_clk(programmable_output_one)
	);

	// peripheral gates, one per identifier
	genvar id;
	generate
		for (id = PERIPHERAL_FIRST; id <= PERIPHERAL_LAST; id++) begin : g_peripheral
			if (implemented_peripherals[id]) begin : g_present
				clock_gate_cell #(
					.reset_open(PERIPHERAL_STATUS_RESET[id])
				) peripheral_gate_bit (
					.clk(pclk),
					.presetn(presetn),
					.enable(peripheral_gate[id]),
					.gated_clk(peripheral_clock[id])
				);
			end else begin : g_absent
				// no peripheral behind this identifier, clock stays low
				assign peripheral_clock[id] = 1'b0;
			end
		end
	endgenerate

	// identifiers 0 and 1 have no gate
	assign peripheral_clock[PERIPHERAL_FIRST-1:0] = 2'b00;

endmodule : clock_gate_enable_status

/* testbench/clock_gate_properties.sv */
// Purpose: assertions on the apb side and processor gate
// Assumes: two cycle apb transfers, prdata loaded in setup
// Notes: gated clock levels are judged by the bench
`timescale 1ns/1ps
module clock_gate_properties import clock_gate_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic processor_wake,
	input wire logic processor_idle
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// transfer phases
	wire logic rd_setup = psel & ~penable & ~pwrite;
	wire logic wr_done = psel & penable & pwrite & pready;
	wire logic wo_addr = paddr inside {OFF_SYSTEM_CLOCK_ENABLE, OFF_SYSTEM_CLOCK_DISABLE,
		OFF_PERIPHERAL_CLOCK_ENABLE, OFF_PERIPHERAL_CLOCK_DISABLE};
	ready_in_access_a: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	proc_stop_a: assert property (wr_done && paddr == OFF_SYSTEM_CLOCK_DISABLE
		&& pwdata[0] && !processor_wake |=> processor_idle) else $error("processor not idled");
	wake_runs_a: assert property (processor_wake |=> !processor_idle)
		else $error("wake did not restart processor");
	idle_holds_a: assert property (processor_idle && !processor_wake |=> processor_idle)
		else $error("processor left idle without wake");
	status_bit0_a: assert property (rd_setup && paddr == OFF_SYSTEM_CLOCK_STATUS |=>
		prdata[0] == !$past(processor_idle) && prdata[1] && !pslverr) else $error("bad status");
	per_low_zero_a: assert property (rd_setup && paddr == OFF_PERIPHERAL_CLOCK_STATUS
		|=> prdata[1:0] == 2'b00) else $error("peripheral bits 1..0 not zero");
	wo_read_zero_a: assert property (rd_setup && wo_addr |=> prdata == READ_ZERO && !pslverr)
		else $error("write-only read not zero");
	unmapped_err_a: assert property (psel && !penable && paddr == 8'h0c |=> pslverr)
		else $error("unmapped access without error");
endmodule : clock_gate_properties
bind clock_gate_enable_status clock_gate_properties clock_gate_properties_i (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .processor_wake,
	.processor_idle);

/* testbench/tb_top.sv */
// Purpose: apb bench for the clock gate block
// Assumes: pready is waited for, never assumed
// Notes: gated clocks are sampled mid high phase
`timescale 1ns/1ps
module tb_top import clock_gate_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, processor_wake = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, peripheral_clock;
	logic pready, pslverr, err, processor_clock, processor_idle, host_port_clock;
	logic device_port_clock, programmable_output_zero, programmable_output_one;
	int num_errors = 0, comparisons = 0, cycles = 0;
	clock_gate_enable_status clock_gate_enable_status_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .processor_wake, .processor_clock,
		.processor_idle, .host_port_clock, .device_port_clock, .programmable_output_zero,
		.programmable_output_one, .peripheral_clock);
	// clock and hang guard
	initial forever #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// one apb transfer, read data taken at the pready edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// status registers, gated clock levels and idle flag
	task automatic expect_state(input logic [31:0] sys, input logic [31:0] per);
		xfer(1'b0, OFF_SYSTEM_CLOCK_STATUS, 32'h0);
		check("sys status", sys, rd);
		xfer(1'b0, OFF_PERIPHERAL_CLOCK_STATUS, 32'h0);
		check("per status", per, rd);
		@(posedge pclk);
		#25;
		check("sys clocks", {27'h0, sys[0], sys[6], sys[7], sys[8], sys[9]},
			{27'h0, processor_clock, host_port_clock, device_port_clock,
			programmable_output_zero, programmable_output_one});
		check("per clocks", per, peripheral_clock);
		check("idle", {31'h0, !sys[0]}, {31'h0, processor_idle});
		// realign to a rising edge before the next stimulus
		@(posedge pclk);
	endtask : expect_state
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		expect_state(32'h3, 32'h0);
		$display("test reset done");
		xfer(1'b1, OFF_SYSTEM_CLOCK_ENABLE, 32'hffff_ffff);
		expect_state(32'h3c3, 32'h0);
		xfer(1'b1, OFF_SYSTEM_CLOCK_DISABLE, 32'h0);
		expect_state(32'h3c3, 32'h0);
		xfer(1'b1, OFF_SYSTEM_CLOCK_DISABLE, 32'h0000_0141);
		expect_state(32'h282, 32'h0);
		xfer(1'b1, OFF_SYSTEM_CLOCK_DISABLE, 32'h0000_0280);
		expect_state(32'h2, 32'h0);
		xfer(1'b1, OFF_SYSTEM_CLOCK_ENABLE, 32'h0000_0001);
		xfer(1'b1, OFF_SYSTEM_CLOCK_STATUS, 32'hffff_ffff);
		expect_state(32'h2, 32'h0);
		processor_wake <= 1'b1;
		@(posedge pclk);
		processor_wake <= 1'b0;
		xfer(1'b1, OFF_SYSTEM_CLOCK_ENABLE, 32'h0000_00c0);
		expect_state(32'h0c3, 32'h0);
		processor_wake <= 1'b1;
		xfer(1'b1, OFF_SYSTEM_CLOCK_DISABLE, 32'h0000_0001);
		processor_wake <= 1'b0;
		expect_state(32'h0c3, 32'h0);
		$display("test system gates done");
		xfer(1'b1, OFF_PERIPHERAL_CLOCK_ENABLE, 32'hffff_ffff);
		expect_state(32'h0c3, 32'hffff_fffc);
		xfer(1'b1, OFF_PERIPHERAL_CLOCK_DISABLE, 32'h0000_0010);
		expect_state(32'h0c3, 32'hffff_ffec);
		xfer(1'b1, OFF_PERIPHERAL_CLOCK_DISABLE, 32'hffff_ffff);
		xfer(1'b1, OFF_PERIPHERAL_CLOCK_ENABLE, 32'h0000_0113);
		expect_state(32'h0c3, 32'h0000_0110);
		xfer(1'b0, 8'h0c, 32'h0);
		check("unmapped err", 32'h1, {31'h0, err});
		xfer(1'b0, OFF_SYSTEM_CLOCK_ENABLE, 32'h0);
		check("write-only read", 32'h0, rd);
		$display("test peripheral gates done");
		test_done();
	end
endmodule : tb_top
